// >>> design/ecp_map.svh
// register offsets, field positions, reset values and timing counts for the pwm unit
`ifndef ECP_MAP_SVH
`define ECP_MAP_SVH
`define ECP_OFF_CON1 8'h00
`define ECP_OFF_LOW1 8'h04
`define ECP_OFF_HIGH1 8'h08
`define ECP_OFF_CON2 8'h0c
`define ECP_OFF_LOW2 8'h10
`define ECP_OFF_HIGH2 8'h14
`define ECP_OFF_PERIOD 8'h18
`define ECP_OFF_DEAD 8'h1c
`define ECP_OFF_SHUT 8'h20
`define ECP_OFF_TCTL 8'h24
`define ECP_OFF_CAPL 8'h28
`define ECP_OFF_CAPH 8'h2c
`define ECP_OFF_PORT 8'h30
`define ECP_CON_RST 8'h00
`define ECP_SHUT_RST 8'h00
`define ECP_TCTL_RST 8'h00
`define ECP_PERIOD_RST 8'hff
`define ECP_PORT_RST 8'h1f
`define ECP_SHUT_EVT 7
`define ECP_CAP_ASYNC_BIT 2
`define ECP_TICK_OSC 4
`endif

// >>> design/ecp_pkg.sv
// types shared by the pwm unit
package ecp_pkg;
	typedef enum logic [3:0] {
		ECP_SINGLE = 4'h1,
		ECP_FWD = 4'h2,
		ECP_HALF = 4'h4,
		ECP_REV = 4'h8
	} ecp_steer_e;
endpackage

// >>> design/ecp_unit.sv
// capture/compare/pwm unit with enhanced bridge steering and auto-shutdown
`timescale 1ns/10ps
`include "ecp_map.svh"

module ecp_unit #(
	parameter int DW = 8
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic second_module_pin_select,
	input wire logic [4:0] port_direction_bits,
	input wire logic port_c_bit1_pin,
	input wire logic port_b_bit3_pin,
	input wire logic cap1_pin,
	input wire logic fault_input_pin,
	input wire logic cmp1_in,
	input wire logic cmp2_in,
	output logic port_c_bit1_pin_o,
	output logic port_c_bit1_pin_oe,
	output logic port_b_bit3_pin_o,
	output logic port_b_bit3_pin_oe,
	output logic bridge_out_a,
	output logic bridge_out_a_oe,
	output logic bridge_out_b,
	output logic bridge_out_b_oe,
	output logic bridge_out_c,
	output logic bridge_out_c_oe,
	output logic bridge_out_d,
	output logic bridge_out_d_oe,
	output logic adc_start,
	output logic pwm_period_irq
);
	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	logic [DW-1:0] con1_reg, low1_reg, high1_reg, con2_reg, low2_reg, high2_reg;
	logic [DW-1:0] period_reg, dead_reg, shut_reg, tctl_reg;
	logic [15:0] t1_reg;
	logic [7:0] t2_reg;
	logic [13:0] t2fine_reg;
	logic [3:0] pre_reg;
	logic [1:0] tq_reg;
	logic [9:0] duty1_reg, duty2_reg;
	logic [8:0] dbcnt_reg;
	logic pwm1_reg, pwm2_reg, pa_reg, pb_reg, cap1_d_reg, cap2_d_reg;

	// ---------------------------------------------
	// bus decode
	// ---------------------------------------------
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];
	wire sel_con1 = wb_adr_i == `ECP_OFF_CON1;
	wire sel_low1 = wb_adr_i == `ECP_OFF_LOW1;
	wire sel_high1 = wb_adr_i == `ECP_OFF_HIGH1;
	wire sel_con2 = wb_adr_i == `ECP_OFF_CON2;
	wire sel_low2 = wb_adr_i == `ECP_OFF_LOW2;
	wire sel_high2 = wb_adr_i == `ECP_OFF_HIGH2;
	wire sel_period = wb_adr_i == `ECP_OFF_PERIOD;
	wire sel_dead = wb_adr_i == `ECP_OFF_DEAD;
	wire sel_shut = wb_adr_i == `ECP_OFF_SHUT;
	wire sel_tctl = wb_adr_i == `ECP_OFF_TCTL;
	wire sel_capl = wb_adr_i == `ECP_OFF_CAPL;
	wire sel_caph = wb_adr_i == `ECP_OFF_CAPH;

	// ---------------------------------------------
	// mode decode
	// ---------------------------------------------
	// modes: 4..7 capture, 8..b compare, c..f pwm, in the low nibble
	wire m1_cap = con1_reg[3:2] == 2'b01;
	wire m1_cmp = con1_reg[3:2] == 2'b10;
	wire m1_pwm = con1_reg[3:2] == 2'b11;
	wire m2_cap = con2_reg[3:2] == 2'b01;
	wire m2_cmp = con2_reg[3:2] == 2'b10;
	wire m2_pwm = con2_reg[3:2] == 2'b11;
	wire t1_async = tctl_reg[`ECP_CAP_ASYNC_BIT];
	wire t1_on = tctl_reg[0];
	wire t2_on = tctl_reg[1];
	wire [1:0] t2_pre = tctl_reg[5:4]; // 00=1, 01=4, 1x=16
	// ---------------------------------------------
	// time bases
	// ---------------------------------------------
	wire tick = tq_reg == 2'(`ECP_TICK_OSC - 1);
	wire [3:0] pre_max = t2_pre == 2'b00 ? 4'h0 : (t2_pre == 2'b01 ? 4'h3 : 4'hf);
	wire t2_step = t2_on & tick & (pre_reg == pre_max);
	wire t2_wrap = t2_step & (t2_reg == period_reg);
	// duty in clocks: the ten-bit value times the prescale
	wire [13:0] duty1_clk = t2_pre == 2'b00 ? {4'h0, duty1_reg}
		: (t2_pre == 2'b01 ? {2'h0, duty1_reg, 2'b00} : {duty1_reg, 4'h0});
	wire [13:0] duty2_clk = t2_pre == 2'b00 ? {4'h0, duty2_reg}
		: (t2_pre == 2'b01 ? {2'h0, duty2_reg, 2'b00} : {duty2_reg, 4'h0});
	wire [15:0] cmp1_val = {high1_reg, low1_reg};
	wire [15:0] cmp2_val = {high2_reg, low2_reg};
	wire hit1 = m1_cmp & t1_on & (t1_reg == cmp1_val);
	wire hit2 = m2_cmp & t1_on & (t1_reg == cmp2_val);
	wire trig1 = hit1 & (con1_reg[1:0] == 2'b11);
	wire trig2 = hit2 & (con2_reg[1:0] == 2'b11);
	// capture input of module two follows the pin select
	wire cap2_pin = second_module_pin_select ? port_c_bit1_pin : port_b_bit3_pin;
	wire rise1 = cap1_pin & ~cap1_d_reg;
	wire rise2 = cap2_pin & ~cap2_d_reg;
	// asynchronous counting would sample a torn count, so capture is held off
	wire cap1_ev = m1_cap & ~t1_async & rise1;
	wire cap2_ev = m2_cap & ~t1_async & rise2;

	// oscillator quarter counter and timer2 prescaler
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tq_reg <= 2'h0;
			pre_reg <= 4'h0;
		end else begin
			tq_reg <= tq_reg + 2'h1;
			if (tick)
				pre_reg <= (pre_reg == pre_max) ? 4'h0 : pre_reg + 4'h1;
		end
	end

	// timer1 shared by capture and compare; trigger of either module clears it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			t1_reg <= 16'h0000;
		else if (trig1 | trig2)
			t1_reg <= 16'h0000;
		else if (t1_on & tick)
			t1_reg <= t1_reg + 16'h0001;
	end

	// timer2 plus a clock count since the wrap for the duty compare
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			t2_reg <= 8'h00;
			t2fine_reg <= 14'h0000;
		end else if (!t2_on) begin
			t2fine_reg <= 14'h0000;
		end else if (t2_wrap) begin
			t2_reg <= 8'h00;
			t2fine_reg <= 14'h0000;
		end else begin
			if (t2_step)
				t2_reg <= t2_reg + 8'h01;
			t2fine_reg <= t2fine_reg + 14'h0001;
		end
	end

	// both pwms latch duty on the shared period wrap
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			duty1_reg <= 10'h000;
			duty2_reg <= 10'h000;
			pwm1_reg <= 1'b0;
			pwm2_reg <= 1'b0;
			pwm_period_irq <= 1'b0;
		end else begin
			pwm_period_irq <= t2_wrap;
			if (t2_wrap) begin
				duty1_reg <= {low1_reg, con1_reg[5:4]};
				duty2_reg <= {low2_reg, con2_reg[5:4]};
			end
			pwm1_reg <= m1_pwm & t2_on & (t2fine_reg < duty1_clk);
			pwm2_reg <= m2_pwm & t2_on & (t2fine_reg < duty2_clk);
		end
	end

	// ---------------------------------------------
	// dead band and steering
	// ---------------------------------------------
	wire [8:0] db_len = {dead_reg[6:0], 2'b00};
	logic pwm1_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pwm1_q <= 1'b0;
			dbcnt_reg <= 9'h000;
			pa_reg <= 1'b0;
			pb_reg <= 1'b0;
		end else begin
			pwm1_q <= pwm1_reg;
			// the edge cycle itself is the first dead clock, so count one less
			if (pwm1_reg != pwm1_q && db_len != 9'h000) begin
				dbcnt_reg <= db_len - 9'h001;
				pa_reg <= 1'b0;
				pb_reg <= 1'b0;
			end else if (pwm1_reg != pwm1_q) begin
				dbcnt_reg <= 9'h000;
				pa_reg <= pwm1_reg;
				pb_reg <= ~pwm1_reg;
			end else if (dbcnt_reg != 9'h000) begin
				dbcnt_reg <= dbcnt_reg - 9'h001;
			end else begin
				pa_reg <= pwm1_reg;
				pb_reg <= ~pwm1_reg;
			end
		end
	end

	ecp_pkg::ecp_steer_e steer;
	// output arrangement from the two top control bits
	always_comb begin
		case (con1_reg[7:6])
			2'b00: steer = ecp_pkg::ECP_SINGLE;
			2'b01: steer = ecp_pkg::ECP_FWD;
			2'b10: steer = ecp_pkg::ECP_HALF;
			2'b11: steer = ecp_pkg::ECP_REV;
			default: steer = ecp_pkg::ECP_SINGLE;
		endcase
	end

	logic [3:0] norm; // a, b, c, d
	always_comb begin
		norm = 4'h0;
		case (steer)
			ecp_pkg::ECP_SINGLE: norm = {pwm1_reg, 3'b000};
			ecp_pkg::ECP_HALF: norm = {pa_reg, pb_reg, 2'b00};
			ecp_pkg::ECP_FWD: norm = {m1_pwm, 2'b00, pwm1_reg};
			ecp_pkg::ECP_REV: norm = {1'b0, pwm1_reg, m1_pwm, 1'b0};
			default: norm = 4'h0;
		endcase
	end

	// ---------------------------------------------
	// auto-shutdown
	// ---------------------------------------------
	wire [2:0] shutdown_source_select = shut_reg[6:4];
	wire [1:0] shutdown_level_ac = shut_reg[3:2];
	wire [1:0] shutdown_level_bd = shut_reg[1:0];
	wire shut_src = (shutdown_source_select[0] & cmp1_in & ~shutdown_source_select[1])
		| (shutdown_source_select[1] & ~shutdown_source_select[0] & cmp2_in)
		| (shutdown_source_select[1] & shutdown_source_select[0] & (cmp1_in | cmp2_in))
		| (shutdown_source_select[2] & ~fault_input_pin);
	wire shutdown_event_flag = shut_reg[`ECP_SHUT_EVT];
	// the hardware set wins over a software clear in the same cycle
	wire [7:0] shut_next = {(bus_wr & sel_shut ? wd[7] : shutdown_event_flag) | shut_src,
		bus_wr & sel_shut ? wd[6:0] : shut_reg[6:0]};

	// pin drive: outputs only where direction bits are clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bridge_out_a <= 1'b0;
			bridge_out_b <= 1'b0;
			bridge_out_c <= 1'b0;
			bridge_out_d <= 1'b0;
			bridge_out_a_oe <= 1'b0;
			bridge_out_b_oe <= 1'b0;
			bridge_out_c_oe <= 1'b0;
			bridge_out_d_oe <= 1'b0;
		end else begin
			bridge_out_a <= shutdown_event_flag ? shutdown_level_ac[0] : norm[3];
			bridge_out_b <= shutdown_event_flag ? shutdown_level_bd[0] : norm[2];
			bridge_out_c <= shutdown_event_flag ? shutdown_level_ac[0] : norm[1];
			bridge_out_d <= shutdown_event_flag ? shutdown_level_bd[0] : norm[0];
			bridge_out_a_oe <= m1_pwm & ~port_direction_bits[0]
				& ~(shutdown_event_flag & shutdown_level_ac[1]);
			bridge_out_b_oe <= m1_pwm & ~port_direction_bits[1] & (steer != ecp_pkg::ECP_SINGLE)
				& ~(shutdown_event_flag & shutdown_level_bd[1]);
			bridge_out_c_oe <= m1_pwm & ~port_direction_bits[2] & (steer[1] | steer[3])
				& ~(shutdown_event_flag & shutdown_level_ac[1]);
			bridge_out_d_oe <= m1_pwm & ~port_direction_bits[3] & (steer[1] | steer[3])
				& ~(shutdown_event_flag & shutdown_level_bd[1]);
		end
	end

	// module two pin; direction still comes from the direction bit, not the select
	wire m2_out = m2_pwm ? pwm2_reg : (m2_cmp & con2_reg[1:0] == 2'b00 & hit2);
	wire m2_oe = (m2_pwm | m2_cmp) & ~port_direction_bits[4];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_c_bit1_pin_o <= 1'b0;
			port_c_bit1_pin_oe <= 1'b0;
			port_b_bit3_pin_o <= 1'b0;
			port_b_bit3_pin_oe <= 1'b0;
			adc_start <= 1'b0;
			cap1_d_reg <= 1'b0;
			cap2_d_reg <= 1'b0;
		end else begin
			port_c_bit1_pin_o <= second_module_pin_select & m2_out;
			port_c_bit1_pin_oe <= second_module_pin_select & m2_oe;
			port_b_bit3_pin_o <= ~second_module_pin_select & m2_out;
			port_b_bit3_pin_oe <= ~second_module_pin_select & m2_oe;
			adc_start <= trig2;
			cap1_d_reg <= cap1_pin;
			cap2_d_reg <= cap2_pin;
		end
	end

	// ---------------------------------------------
	// register file
	// ---------------------------------------------
	// capture writes the timer into the data bytes; a bus write in the same cycle loses
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			con1_reg <= `ECP_CON_RST;
			low1_reg <= 8'h00;
			high1_reg <= 8'h00;
			con2_reg <= `ECP_CON_RST;
			low2_reg <= 8'h00;
			high2_reg <= 8'h00;
			period_reg <= `ECP_PERIOD_RST;
			dead_reg <= 8'h00;
			shut_reg <= `ECP_SHUT_RST;
			tctl_reg <= `ECP_TCTL_RST;
		end else begin
			shut_reg <= shut_next;
			if (bus_wr & sel_con1) con1_reg <= wd;
			if (bus_wr & sel_con2) con2_reg <= wd;
			if (bus_wr & sel_period) period_reg <= wd;
			if (bus_wr & sel_dead) dead_reg <= wd;
			if (bus_wr & sel_tctl) tctl_reg <= wd;
			if (cap1_ev) begin
				{high1_reg, low1_reg} <= t1_reg;
			end else begin
				if (bus_wr & sel_low1) low1_reg <= wd;
				if (bus_wr & sel_high1) high1_reg <= wd;
			end
			if (cap2_ev) begin
				{high2_reg, low2_reg} <= t1_reg;
			end else begin
				if (bus_wr & sel_low2) low2_reg <= wd;
				if (bus_wr & sel_high2) high2_reg <= wd;
			end
		end
	end

	// read mux; unmapped offsets read zero
	wire [7:0] rd_byte = sel_con1 ? con1_reg : sel_low1 ? low1_reg : sel_high1 ? high1_reg
		: sel_con2 ? con2_reg : sel_low2 ? low2_reg : sel_high2 ? high2_reg
		: sel_period ? period_reg : sel_dead ? dead_reg : sel_shut ? shut_reg
		: sel_tctl ? tctl_reg : sel_capl ? t1_reg[7:0] : sel_caph ? t1_reg[15:8]
		: 8'h00;

	// one-wait ack, dropped the cycle after
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end
endmodule

// >>> tb/ecp_unit_sva.sv
// port checker for the pwm unit
`timescale 1ns/10ps
module ecp_unit_sva (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic second_module_pin_select,
	input wire logic [4:0] port_direction_bits,
	input wire logic port_c_bit1_pin_oe,
	input wire logic port_b_bit3_pin_oe,
	input wire logic bridge_out_a_oe,
	input wire logic bridge_out_b_oe,
	input wire logic bridge_out_c_oe,
	input wire logic bridge_out_d_oe,
	input wire logic adc_start,
	input wire logic pwm_period_irq
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// bus answers exactly one cycle after it takes a request
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("answer longer than one cycle");
	chk_dat_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data wider than a byte");
	// enables are registered, so a direction bit steady for two edges must hold the pin off
	chk_dir_a: assert property (port_direction_bits[0] && $past(port_direction_bits[0])
		|-> !bridge_out_a_oe)
		else $error("output a driven while set as input");
	chk_dir_bcd: assert property ((port_direction_bits[3:1] & $past(port_direction_bits[3:1])
		& {bridge_out_d_oe, bridge_out_c_oe, bridge_out_b_oe}) == 3'b000)
		else $error("output b c or d driven while set as input");
	chk_pin_port_c: assert property (!second_module_pin_select
		&& !$past(second_module_pin_select) |-> !port_c_bit1_pin_oe)
		else $error("port c pin driven while port b selected");
	chk_pin_port_b: assert property (second_module_pin_select
		&& $past(second_module_pin_select) |-> !port_b_bit3_pin_oe)
		else $error("port b pin driven while port c selected");
	chk_pin_dir: assert property (port_direction_bits[4] && $past(port_direction_bits[4])
		|-> !(port_c_bit1_pin_oe || port_b_bit3_pin_oe))
		else $error("module two pin driven while set as input");
	chk_adc_pulse: assert property (adc_start |=> !adc_start)
		else $error("conversion start longer than one cycle");
	// shortest period is four clocks
	chk_wrap_gap: assert property (pwm_period_irq |=> !pwm_period_irq [*3])
		else $error("period wraps closer than four clocks");
endmodule

bind ecp_unit ecp_unit_sva i_chk (
	.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.second_module_pin_select(second_module_pin_select),
	.port_direction_bits(port_direction_bits),
	.port_c_bit1_pin_oe(port_c_bit1_pin_oe), .port_b_bit3_pin_oe(port_b_bit3_pin_oe),
	.bridge_out_a_oe(bridge_out_a_oe), .bridge_out_b_oe(bridge_out_b_oe),
	.bridge_out_c_oe(bridge_out_c_oe), .bridge_out_d_oe(bridge_out_d_oe),
	.adc_start(adc_start), .pwm_period_irq(pwm_period_irq)
);

// >>> tb/ecp_bridge_model.sv
// bridge driver model: resolves the four bridge lines and owns the fault line
`timescale 1ns/10ps
module ecp_bridge_model (
	input wire logic clock,
	input wire logic [3:0] drv,
	input wire logic [3:0] drv_oe,
	input wire logic trip,
	output logic [3:0] lvl,
	output logic fault_n
);
	logic [3:0] float_reg = 4'h5;
	// undriven lines wander each cycle so a lost enable never reads as a clean level
	always_ff @(posedge clock) float_reg <= ~float_reg;
	assign lvl = (drv & drv_oe) | (float_reg & ~drv_oe);
	// fault line has a pull-up, pulled low while the driver trips
	assign fault_n = ~trip;
endmodule

// >>> tb/ecp_unit_test.sv
// self-checking bench for the pwm unit
`timescale 1ns/10ps
module ecp_unit_test;
	logic clock = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic sel_pin = 1'b1, trip = 1'b0, cmp1 = 1'b0, cmp2 = 1'b0, irq, adc, c1, b3, fault_n;
	logic [7:0] adr = 8'h00, q;
	logic [31:0] wdat = 32'h0, rdat;
	logic [4:0] dir = 5'h00;
	logic [3:0] out, oe, lvl;
	int bad_count = 0, num_checks = 0, per, cnt[4];

	ecp_unit i_dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_dat_o(rdat),
		.wb_ack_o(ack), .second_module_pin_select(sel_pin), .port_direction_bits(dir),
		.port_c_bit1_pin(1'b0), .port_b_bit3_pin(1'b0), .cap1_pin(1'b0),
		.fault_input_pin(fault_n), .cmp1_in(cmp1), .cmp2_in(cmp2), .port_c_bit1_pin_o(),
		.port_c_bit1_pin_oe(c1), .port_b_bit3_pin_o(), .port_b_bit3_pin_oe(b3),
		.bridge_out_a(out[0]), .bridge_out_a_oe(oe[0]), .bridge_out_b(out[1]),
		.bridge_out_b_oe(oe[1]), .bridge_out_c(out[2]), .bridge_out_c_oe(oe[2]),
		.bridge_out_d(out[3]), .bridge_out_d_oe(oe[3]), .adc_start(adc), .pwm_period_irq(irq));
	ecp_bridge_model i_bridge (.clock(clock), .drv(out), .drv_oe(oe), .trip(trip),
		.lvl(lvl), .fault_n(fault_n));

	initial forever #20 clock = ~clock;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// classic single cycle, held until ack is sampled, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 40);
		if (n >= 40) begin bad_count++; close_out; end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask

	// two wraps let new duty and period land, then one full period is counted
	task automatic meas;
		int n;
		repeat (2) begin
			n = 0;
			do begin @(posedge clock); n++; end while (irq !== 1'b1 && n < 2000);
		end
		per = 0;
		cnt = '{0, 0, 0, 0};
		do begin
			@(posedge clock);
			per++;
			for (int i = 0; i < 4; i++) cnt[i] += (lvl[i] === 1'b1);
		end while (irq !== 1'b1 && per < 2000);
	endtask

	initial begin
		logic [24:0] rows [12] = '{25'h0_00_00_00, 25'h0_18_00_ff, 25'h0_20_00_00,
			25'h0_24_00_00, 25'h1_00_a5_a5, 25'h1_04_3c_3c, 25'h1_08_c3_c3, 25'h1_0c_5a_5a,
			25'h1_10_0f_0f, 25'h1_14_f0_f0, 25'h1_1c_7f_7f, 25'h1_3c_55_00};
		int exp4 [4][4] = '{'{6, -1, -1, -1}, '{12, 0, 0, 6}, '{6, 6, -1, -1}, '{0, 6, 12, 0}};
		int n;
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		// rows: write flag, offset, data, expected read-back
		foreach (rows[i]) begin
			if (rows[i][24]) bus(1'b1, rows[i][23:16], rows[i][15:8]);
			bus(1'b0, rows[i][23:16], 8'h00);
			check("register", q, rows[i][7:0]);
		end
		$display("done register table");
		// period 2 gives 12 clocks, duty 6 clocks
		bus(1'b1, 8'h18, 8'h02);
		bus(1'b1, 8'h04, 8'h01);
		bus(1'b1, 8'h1c, 8'h00);
		bus(1'b1, 8'h24, 8'h02);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 8'h00, {s[1:0], 6'h2c});
			meas;
			check("period", per, 12);
			for (int i = 0; i < 4; i++)
				if (exp4[s][i] >= 0) check("level count", cnt[i], exp4[s][i]);
		end
		bus(1'b1, 8'h1c, 8'h01);
		bus(1'b1, 8'h00, 8'hac);
		meas;
		check("dead band", cnt[0] + cnt[1], 4);
		bus(1'b1, 8'h1c, 8'h00);
		bus(1'b1, 8'h00, 8'h2c);
		for (int p = 1; p < 3; p++) begin
			bus(1'b1, 8'h24, {2'b00, p[1:0], 4'h2});
			meas;
			check("scaled period", per, 12 << (2 * p));
			check("scaled high", cnt[0], 6 << (2 * p));
		end
		bus(1'b1, 8'h24, 8'h02);
		$display("done pwm shapes");
		// each source code against each trip input
		for (int src = 0; src < 8; src++) for (int k = 0; k < 3; k++) begin
			bus(1'b1, 8'h20, {1'b0, src[2:0], 4'h0});
			{trip, cmp2, cmp1} <= 3'b001 << k;
			repeat (3) @(posedge clock);
			{trip, cmp2, cmp1} <= 3'b000;
			repeat (3) @(posedge clock);
			bus(1'b0, 8'h20, 8'h00);
			check("shutdown flag", q, {src[k], src[2:0], 4'h0});
			bus(1'b1, 8'h20, 8'h00);
		end
		bus(1'b1, 8'h00, 8'h6c);
		bus(1'b1, 8'h20, 8'h44);
		trip <= 1'b1;
		repeat (3) @(posedge clock);
		trip <= 1'b0;
		repeat (3) @(posedge clock);
		check("shutdown levels", lvl, 4'b0101);
		bus(1'b1, 8'h20, 8'hca);
		repeat (2) @(posedge clock);
		check("shutdown float", oe, 4'h0);
		bus(1'b1, 8'h20, 8'h00);
		dir <= 5'h0f;
		repeat (3) @(posedge clock);
		check("direction", oe, 4'h0);
		$display("done shutdown");
		bus(1'b1, 8'h0c, 8'h0c);
		for (int m = 0; m < 4; m++) begin
			{dir[4], sel_pin} <= m[1:0];
			repeat (3) @(posedge clock);
			check("pin enable", {c1, b3}, m[1] ? 2'b00 : (m[0] ? 2'b10 : 2'b01));
		end
		// compare match on module two fires the conversion start
		bus(1'b1, 8'h10, 8'h05);
		bus(1'b1, 8'h14, 8'h00);
		bus(1'b1, 8'h0c, 8'h0b);
		bus(1'b1, 8'h24, 8'h03);
		n = 0;
		do begin @(posedge clock); n++; end while (adc !== 1'b1 && n < 1000);
		check("conversion start", n < 1000, 1);
		$display("done module two");
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		check("reset enables", {oe, c1, b3}, 6'h0);
		reset_n <= 1'b1;
		@(posedge clock);
		bus(1'b0, 8'h18, 8'h00);
		check("period after reset", q, 8'hff);
		$display("done second reset");
		close_out;
	end
endmodule
